//--- shared/sssel_defines.svh
`ifndef SSSEL_DEFINES_SVH
`define SSSEL_DEFINES_SVH

`define SSSEL_CLK_HZ        25000000
`define SSSEL_MS_PER_S      1000
`define SSSEL_MS_CYCLES     (`SSSEL_CLK_HZ / `SSSEL_MS_PER_S)

`define SSSEL_OFS_CTRL      8'h00
`define SSSEL_OFS_TIME      8'h04
`define SSSEL_OFS_TORQUE    8'h08
`define SSSEL_OFS_STATUS    8'h0C

`define SSSEL_CTRL_SOS_LSB  0
`define SSSEL_CTRL_POS_LSB  4
`define SSSEL_CTRL_UVT_LSB  8
`define SSSEL_CTRL_ALS_LSB  12
`define SSSEL_TIME_DET_LSB  0
`define SSSEL_TIME_WDL_LSB  16
`define SSSEL_STAT_UV_BIT   2

`define SSSEL_SEQ_MAX       4'h9
`define SSSEL_DET_MIN       11'h014
`define SSSEL_DET_MAX       11'h7D0
`define SSSEL_TRQ_MAX       9'h1F4

`define SSSEL_RST_SOS       4'h0
`define SSSEL_RST_POS       4'h0
`define SSSEL_RST_UVT       2'h1
`define SSSEL_RST_ALS       3'h0
`define SSSEL_RST_DET       11'h046
`define SSSEL_RST_WDL       11'h3E8
`define SSSEL_RST_TRQ       9'h000

`define SSSEL_RESP_OKAY     2'h0
`define SSSEL_RESP_SLVERR   2'h2

`endif

//--- shared/sssel_pkg.sv
`default_nettype none

package sssel_pkg;
  typedef enum logic [1:0] {
    SSSEL_RUN,
    SSSEL_DECEL,
    SSSEL_STOP
  } sssel_state_t;

  typedef enum logic [1:0] {
    SSSEL_DEC_DB,
    SSSEL_DEC_FREE,
    SSSEL_DEC_ESTOP
  } sssel_decel_t;
endpackage

`default_nettype wire

//--- hw/sssel_timer.sv
`include "sssel_defines.svh"
`default_nettype none

module sssel_timer (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic [10:0] limit,
  output logic             done
);
  logic [10:0] cnt_q;

  // Counts whole milliseconds while run stays high; any drop restarts it
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      cnt_q <= 11'h000;
      done  <= 1'b0;
    end else begin
      if (tick && cnt_q != limit) begin
        cnt_q <= cnt_q + 11'h001;
      end
      done <= (cnt_q == limit);
    end
  end
endmodule

`default_nettype wire

//--- hw/sssel_top.sv
// Summary of operation
// R01: Emergency stop keeps servo on, torque limited
// R02: Below 30 r/min deceleration ends, stop latched
// R03: Clearing servo-off selections zero both deviations
// R04: Error during servo-off uses alarm selection
// R05: Power loss during servo-off uses power-off selection
// R06: Power-off selection 0-9 maps like servo-off
// R07: Error during power-off uses alarm selection
// R08: Power loss at servo-on, trip bit0: undervoltage
// R09: Trip bit0 clear: servo-off, auto resume
// R10: Trip bit1 picks warning detection condition
// R11: Warning only after warning delay expires
// R12: Trip selection void when detect time 2000
// R13: Low bus voltage before detection: undervoltage error
// R14: Loss recognised after continuous detect time
// R15: Detect time 2000 disables power-off detection
// R16: Alarm selection 0-3: brake or free-run
// R17: Alarm 4-7: estop if needed, else brake/free-run
// R18: Alarm holds deviation, clears on cancel
// R19: Estop torque 0-500 percent, 0 normal
// R20: Host stops commands while deviation held
// R21: Servo-off map: clear, hold, estop groups
// R22: Registered brake, estop, torque, deviation outputs
`include "sssel_defines.svh"
`default_nettype none

module sssel_top #(
  parameter int MS_CYCLES = `SSSEL_MS_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                servo_on_cmd,
  input  wire logic                main_power_ok,
  input  wire logic                bus_voltage_low,
  input  wire logic                alarm_active,
  input  wire logic                alarm_needs_estop,
  input  wire logic                speed_below_30,
  output logic                     dynamic_brake,
  output logic                     estop_req,
  output logic                     servo_enable,
  output logic                     torque_limit_sel,
  output logic [8:0]               torque_limit_pct,
  output logic                     deviation_clear,
  output logic                     deviation_hold,
  output logic                     main_undervoltage_error,
  output logic                     power_off_warning,
  output sssel_pkg::sssel_state_t  stop_phase,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import sssel_pkg::*;

  // Register index for an address, 3'h4 when unmapped
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    case (addr)
      `SSSEL_OFS_CTRL:   reg_index = 3'h0;
      `SSSEL_OFS_TIME:   reg_index = 3'h1;
      `SSSEL_OFS_TORQUE: reg_index = 3'h2;
      `SSSEL_OFS_STATUS: reg_index = 3'h3;
      default:           reg_index = 3'h4;
    endcase
  endfunction

  // Stop sequence decode: {clear, after_free, decel}
  function automatic logic [3:0] seq_decode(input logic alarm, input logic [3:0] sel,
                                            input logic need_estop);
    sssel_decel_t dm;
    dm = sel[0] ? SSSEL_DEC_FREE : SSSEL_DEC_DB;
    if (alarm) begin
      if (sel[2] && need_estop) begin
        dm = SSSEL_DEC_ESTOP;                                       // [R17]
      end
      seq_decode = {1'b0, sel[1], dm};                               // [R16] [R18]
    end else if (sel[3]) begin
      seq_decode = {1'b1, sel[0], SSSEL_DEC_ESTOP};                  // [R21]
    end else begin
      seq_decode = {!sel[2], sel[1], dm};                            // [R21] [R03]
    end
  endfunction

  logic [3:0]   sos_q;
  logic [3:0]   pos_q;
  logic [1:0]   uvt_q;
  logic [2:0]   als_q;
  logic [10:0]  det_q;
  logic [10:0]  wdl_q;
  logic [8:0]   etl_q;
  logic [15:0]  div_q;
  logic         ms_tick_q;
  logic         power_lost_q;
  logic         alarm_prev_q;
  sssel_state_t state_q;
  sssel_state_t state_d;

  logic         aw_have_q;
  logic         w_have_q;
  logic [7:0]   awaddr_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;

  // Bus handshakes and write merge
  wire          aw_take  = s_axi_awvalid && s_axi_awready;
  wire          w_take   = s_axi_wvalid && s_axi_wready;
  wire          ar_take  = s_axi_arvalid && s_axi_arready;
  wire          do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  wire [2:0]    w_idx    = reg_index(awaddr_q);
  wire [2:0]    r_idx    = reg_index(s_axi_araddr);
  wire [31:0]   bmask;
  wire [31:0]   ctrl_rd;
  wire [31:0]   time_rd;
  wire [31:0]   trq_rd;
  wire [31:0]   stat_rd;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mask
      assign bmask[gi*8 +: 8] = {8{wstrb_q[gi]}};
    end
  endgenerate

  assign ctrl_rd = {17'h00000, als_q, 2'h0, uvt_q, pos_q, sos_q};
  assign time_rd = {5'h00, wdl_q, 5'h00, det_q};
  assign trq_rd  = {23'h000000, etl_q};
  assign stat_rd = {22'h000000, servo_enable, deviation_hold, deviation_clear,
                    estop_req, dynamic_brake, power_lost_q, power_off_warning,
                    main_undervoltage_error, stop_phase};

  wire [31:0] ctrl_m = (ctrl_rd & ~bmask) | (wdata_q & bmask);
  wire [31:0] time_m = (time_rd & ~bmask) | (wdata_q & bmask);
  wire [31:0] trq_m  = (trq_rd & ~bmask) | (wdata_q & bmask);
  wire [3:0]  sos_w  = ctrl_m[`SSSEL_CTRL_SOS_LSB +: 4];
  wire [3:0]  pos_w  = ctrl_m[`SSSEL_CTRL_POS_LSB +: 4];
  wire [10:0] det_w  = time_m[`SSSEL_TIME_DET_LSB +: 11];
  wire [8:0]  etl_w  = trq_m[8:0];
  wire        wr_ctrl = do_write && w_idx == 3'h0;
  wire        wr_time = do_write && w_idx == 3'h1;
  wire        wr_trq  = do_write && w_idx == 3'h2;
  wire        uv_clr  = do_write && w_idx == 3'h3 && wstrb_q[0]
                        && wdata_q[`SSSEL_STAT_UV_BIT];

  // Power monitoring
  wire power_off  = !main_power_ok;
  wire detect_en  = det_q != `SSSEL_DET_MAX;                         // [R15] [R12]
  wire servo_on   = state_q == SSSEL_RUN;
  wire warn_cond  = power_off && detect_en && (uvt_q[1] || servo_on); // [R10]
  wire pl_done;
  wire warn_done;
  wire lost_edge  = pl_done && !power_lost_q;
  wire uv_trip    = lost_edge && servo_on && uvt_q[0];               // [R08]
  wire uv_bus     = power_off && bus_voltage_low && !power_lost_q;   // [R13]
  wire uv_set     = uv_trip || uv_bus;
  wire uv_d       = uv_set || (main_undervoltage_error && !uv_clr);

  sssel_timer u_detect (
    .clk   (clk),
    .reset (reset),
    .tick  (ms_tick_q),
    .run   (power_off && detect_en),                                 // [R14]
    .limit (det_q),
    .done  (pl_done)
  );

  sssel_timer u_warn (
    .clk   (clk),
    .reset (reset),
    .tick  (ms_tick_q),
    .run   (warn_cond),                                              // [R11]
    .limit (wdl_q),
    .done  (warn_done)
  );

  // Stop source priority: alarm, then power loss, then servo-off
  wire        alarm_any  = alarm_active || main_undervoltage_error;  // [R04] [R07]
  wire        alarm_fall = alarm_prev_q && !alarm_any;               // [R18]
  wire        stop_req   = alarm_any || power_lost_q || !servo_on_cmd; // [R09]
  wire [3:0]  src_sel    = alarm_any ? {1'b0, als_q} :
                           power_lost_q ? pos_q : sos_q;             // [R05] [R06]
  wire [3:0]  seq        = seq_decode(alarm_any, src_sel, alarm_needs_estop);
  wire        seq_clear  = seq[3];
  wire        seq_afree  = seq[2];
  wire [1:0]  seq_decel  = seq[1:0];

  always_comb begin
    state_d = state_q;
    case (state_q)
      SSSEL_RUN: begin
        if (stop_req) begin
          state_d = speed_below_30 ? SSSEL_STOP : SSSEL_DECEL;       // [R02]
        end
      end
      SSSEL_DECEL: begin
        if (!stop_req) begin
          state_d = SSSEL_RUN;
        end else if (speed_below_30) begin
          state_d = SSSEL_STOP;                                      // [R02]
        end
      end
      SSSEL_STOP: begin
        if (!stop_req) begin
          state_d = SSSEL_RUN;
        end
      end
      default: state_d = SSSEL_RUN;
    endcase
  end

  // Power stage commands for the coming cycle
  wire stopping = state_d != SSSEL_RUN;
  wire in_decel = state_d == SSSEL_DECEL;
  wire estop_d  = in_decel && seq_decel == SSSEL_DEC_ESTOP;          // [R01]
  wire db_d     = in_decel ? (seq_decel == SSSEL_DEC_DB) :
                  (stopping && !seq_afree);
  wire clr_d    = (stopping && seq_clear) || alarm_fall;             // [R03] [R18]
  wire hold_d   = stopping && !seq_clear && !alarm_fall;             // [R18] [R20]

  always_ff @(posedge clk) begin
    if (reset) begin
      div_q                   <= 16'h0000;
      ms_tick_q               <= 1'b0;
      power_lost_q            <= 1'b0;
      alarm_prev_q            <= 1'b0;
      state_q                 <= SSSEL_RUN;
      dynamic_brake           <= 1'b0;
      estop_req               <= 1'b0;
      servo_enable            <= 1'b0;
      torque_limit_sel        <= 1'b0;
      torque_limit_pct        <= `SSSEL_RST_TRQ;
      deviation_clear         <= 1'b0;
      deviation_hold          <= 1'b0;
      main_undervoltage_error <= 1'b0;
      power_off_warning       <= 1'b0;
      stop_phase              <= SSSEL_RUN;
    end else begin
      ms_tick_q               <= div_q == 16'(MS_CYCLES - 1);
      div_q                   <= (div_q == 16'(MS_CYCLES - 1)) ? 16'h0000 : div_q + 16'h0001;
      power_lost_q            <= pl_done;                            // [R14] [R09]
      alarm_prev_q            <= alarm_any;
      state_q                 <= state_d;
      stop_phase              <= state_d;
      dynamic_brake           <= db_d;                               // [R22]
      estop_req               <= estop_d;                            // [R22]
      servo_enable            <= !stopping || estop_d;               // [R01]
      torque_limit_sel        <= estop_d && etl_q != 9'h000;         // [R19]
      torque_limit_pct        <= etl_q;
      deviation_clear         <= clr_d;                              // [R22]
      deviation_hold          <= hold_d;
      main_undervoltage_error <= uv_d;
      power_off_warning       <= warn_done;                          // [R11]
    end
  end

  // Settings registers; out-of-range values leave the field unchanged
  always_ff @(posedge clk) begin
    if (reset) begin
      sos_q <= `SSSEL_RST_SOS;
      pos_q <= `SSSEL_RST_POS;
      uvt_q <= `SSSEL_RST_UVT;
      als_q <= `SSSEL_RST_ALS;
      det_q <= `SSSEL_RST_DET;
      wdl_q <= `SSSEL_RST_WDL;
      etl_q <= `SSSEL_RST_TRQ;
    end else begin
      if (wr_ctrl) begin
        if (sos_w <= `SSSEL_SEQ_MAX) sos_q <= sos_w;                 // [R21]
        if (pos_w <= `SSSEL_SEQ_MAX) pos_q <= pos_w;                 // [R06]
        uvt_q <= ctrl_m[`SSSEL_CTRL_UVT_LSB +: 2];                   // [R09]
        als_q <= ctrl_m[`SSSEL_CTRL_ALS_LSB +: 3];                   // [R16]
      end
      if (wr_time) begin
        if (det_w >= `SSSEL_DET_MIN && det_w <= `SSSEL_DET_MAX) begin
          det_q <= det_w;                                            // [R14]
        end
        wdl_q <= time_m[`SSSEL_TIME_WDL_LSB +: 11];
      end
      if (wr_trq && etl_w <= `SSSEL_TRQ_MAX) begin
        etl_q <= etl_w;                                              // [R19]
      end
    end
  end

  // AXI4-Lite slave, one write and one read in flight
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SSSEL_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SSSEL_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (w_idx == 3'h4) ? `SSSEL_RESP_SLVERR : `SSSEL_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_awready <= !(aw_take || (aw_have_q && !do_write));
      s_axi_wready  <= !(w_take || (w_have_q && !do_write));
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= (r_idx == 3'h4) ? `SSSEL_RESP_SLVERR : `SSSEL_RESP_OKAY;
        case (r_idx)
          3'h0:    s_axi_rdata <= ctrl_rd;
          3'h1:    s_axi_rdata <= time_rd;
          3'h2:    s_axi_rdata <= trq_rd;
          3'h3:    s_axi_rdata <= stat_rd;
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !(ar_take || (s_axi_rvalid && !s_axi_rready));
    end
  end

  sequence s_power_lost_edge;
    pl_done && !power_lost_q;
  endsequence

  sequence s_lost_at_run;
    s_power_lost_edge ##0 servo_on && uvt_q[0];
  endsequence

  estop_servo_on_a: assert property (@(posedge clk) disable iff (reset) // [R01]
    estop_req |-> servo_enable && !dynamic_brake)
    else $error("estop without servo enable");

  estop_torque_a: assert property (@(posedge clk) disable iff (reset) // [R19]
    torque_limit_sel |-> estop_req && torque_limit_pct != 9'h000)
    else $error("estop torque limit misapplied");

  stop_latched_a: assert property (@(posedge clk) disable iff (reset) // [R02]
    state_q == SSSEL_STOP && stop_req |=> state_q == SSSEL_STOP)
    else $error("stop state left while stop requested");

  servo_off_clear_a: assert property (@(posedge clk) disable iff (reset) // [R03]
    !alarm_any && !power_lost_q && !servo_on_cmd && sos_q < 4'h4
    |=> deviation_clear)
    else $error("clearing selection did not clear deviation");

  alarm_hold_a: assert property (@(posedge clk) disable iff (reset) // [R18]
    alarm_any && alarm_prev_q |=> deviation_hold && !deviation_clear)
    else $error("deviation not held during alarm");

  uv_trip_a: assert property (@(posedge clk) disable iff (reset) // [R08]
    s_lost_at_run |=> main_undervoltage_error [*2])
    else $error("undervoltage trip missing");

  uv_bus_a: assert property (@(posedge clk) disable iff (reset) // [R13]
    power_off && bus_voltage_low && !power_lost_q |=> main_undervoltage_error)
    else $error("bus undervoltage not raised");

  detect_off_a: assert property (@(posedge clk) disable iff (reset) // [R15]
    det_q == `SSSEL_DET_MAX |=> ##1 !power_lost_q)
    else $error("power loss detected while disabled");

  warn_power_a: assert property (@(posedge clk) disable iff (reset) // [R11]
    power_off_warning |-> $past(power_off, 2))
    else $error("warning without power off");
endmodule

`default_nettype wire

//--- dv/sssel_motor_model.sv
`default_nettype none

module sssel_motor_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic servo_enable,
  input  wire logic estop_req,
  input  wire logic dynamic_brake,
  input  wire logic kick,
  output logic      speed_below_30
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] spd_q;
  // Driven motor runs at full speed; braking sheds speed twice as fast as coasting
  always_ff @(posedge clk) begin
    if (reset || kick || (servo_enable && !estop_req)) begin
      spd_q <= 8'h50;
    end else if (spd_q != 8'h00) begin
      spd_q <= spd_q - (((dynamic_brake || estop_req) && spd_q > 8'h01) ? 8'h02 : 8'h01);
    end
  end
  assign speed_below_30 = spd_q < 8'h10;
endmodule

`default_nettype wire

//--- dv/sssel_top_tb.sv
`include "sssel_defines.svh"
`default_nettype none

module sssel_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sssel_pkg::*;
  localparam int MS = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic servo_on_cmd = 1'b0, main_power_ok = 1'b1, bus_voltage_low = 1'b0;
  logic alarm_active = 1'b0, alarm_needs_estop = 1'b0, kick = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic speed_below_30, dynamic_brake, estop_req, servo_enable, torque_limit_sel;
  logic deviation_clear, deviation_hold, main_undervoltage_error, power_off_warning;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [8:0] torque_limit_pct, tq;
  logic [1:0] s_axi_bresp, s_axi_rresp, lr;
  logic [31:0] s_axi_rdata, rdat, rnd = 32'h930483AB;
  logic [3:0] ps;
  logic seen;
  sssel_state_t stop_phase;
  int failures = 0, total_checks = 0, cyc = 0;

  always #20 clk = ~clk;

  sssel_top #(.MS_CYCLES(MS)) dut (.clk, .reset, .servo_on_cmd, .main_power_ok,
    .bus_voltage_low, .alarm_active, .alarm_needs_estop, .speed_below_30, .dynamic_brake,
    .estop_req, .servo_enable, .torque_limit_sel, .torque_limit_pct, .deviation_clear,
    .deviation_hold, .main_undervoltage_error, .power_off_warning, .stop_phase,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  sssel_motor_model motor (.clk, .reset, .servo_enable, .estop_req, .dynamic_brake, .kick,
    .speed_below_30);

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // Servo-off and power-off map: {enable, estop, brake, clear, hold}
  function automatic logic [4:0] eso(input logic [3:0] v, input logic st);
    logic es, db, cl;
    es = !st && v > 4'h7;
    db = st ? (v < 4'h8 ? !v[1] : !v[0]) : (v < 4'h8 && !v[0]);
    cl = !(v > 4'h3 && v < 4'h8);
    return {es, es, db, cl, !cl};
  endfunction

  function automatic logic [4:0] eal(input logic [2:0] v, input logic n, input logic st);
    logic es, db;
    es = !st && v[2] && n;
    db = st ? !v[1] : (!es && !v[0]);
    return {es, es, db, 2'h1};
  endfunction

  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic ck(input logic [4:0] e);
    chk({27'h0, servo_enable, estop_req, dynamic_brake, deviation_clear, deviation_hold},
      {27'h0, e}, "outputs");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    lr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    lr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wctl(input logic [3:0] s, input logic [3:0] p, input logic [1:0] u,
                      input logic [2:0] al);
    wr(`SSSEL_OFS_CTRL, {17'h00000, al, 2'h0, u, p, s});
  endtask

  task automatic wtime(input logic [10:0] d, input logic [10:0] w);
    wr(`SSSEL_OFS_TIME, {5'h00, w, 5'h00, d});
  endtask

  task automatic wph(input sssel_state_t p);
    do @(posedge clk); while (stop_phase !== p);
  endtask

  task automatic cph(input sssel_state_t p);
    chk({30'h0, stop_phase}, {30'h0, p}, "phase");
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      complete_run();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    rd(`SSSEL_OFS_CTRL);
    chk(rdat, 32'h0000_0100, "ctrl reset");
    rd(`SSSEL_OFS_TIME);
    chk(rdat, 32'h03E8_0046, "time reset");
    rd(`SSSEL_OFS_TORQUE);
    chk(rdat, 32'h0000_0000, "torque reset");
    rd(8'h10);
    chk({28'h0, lr, rdat[31:30]}, {28'h0, `SSSEL_RESP_SLVERR, 2'h0}, "unmapped");
    wr(`SSSEL_OFS_TORQUE, 32'h0000_01F5);
    chk({30'h0, lr}, {30'h0, `SSSEL_RESP_OKAY}, "write resp");
    rd(`SSSEL_OFS_TORQUE);
    chk(rdat, 32'h0000_0000, "torque range");
    rnd = xs(rnd);
    tq = 9'(rnd % 32'h1F4) + 9'h001;
    wr(`SSSEL_OFS_TORQUE, {23'h0, tq});
    for (int v = 0; v < 10; v++) begin
      if (v == 9) wr(`SSSEL_OFS_TORQUE, 32'h0000_0000);
      wctl(4'(v), 4'h0, 2'h0, 3'h0);
      servo_on_cmd <= 1'b1;
      wph(SSSEL_RUN);
      repeat (2) @(posedge clk);
      // No position commands are issued while stopped
      servo_on_cmd <= 1'b0;
      repeat (3) @(posedge clk);
      ck(eso(4'(v), 1'b0));
      if (v > 7) chk({22'h0, torque_limit_sel, torque_limit_pct},
        {22'h0, v == 8, (v == 8) ? tq : 9'h000}, "torque");
      wph(SSSEL_STOP);
      repeat (2) @(posedge clk);
      ck(eso(4'(v), 1'b1));
      kick <= 1'b1;
      @(posedge clk);
      kick <= 1'b0;
      repeat (3) @(posedge clk);
      cph(SSSEL_STOP);
    end
    for (int v = 0; v < 8; v++) begin
      rnd = xs(rnd);
      wctl(4'h4, 4'h0, 2'h0, 3'(v));
      alarm_needs_estop <= rnd[0];
      servo_on_cmd <= (v != 3);
      wph((v == 3) ? SSSEL_STOP : SSSEL_RUN);
      repeat (2) @(posedge clk);
      alarm_active <= 1'b1;
      repeat (3) @(posedge clk);
      if (v != 3) ck(eal(3'(v), rnd[0], 1'b0));
      wph(SSSEL_STOP);
      repeat (2) @(posedge clk);
      ck(eal(3'(v), rnd[0], 1'b1));
      alarm_active <= 1'b0;
      seen = 1'b0;
      repeat (4) begin
        @(posedge clk);
        seen = seen | deviation_clear;
      end
      chk({31'h0, seen}, 32'h1, "clear on cancel");
    end
    rnd = xs(rnd);
    ps = 4'(rnd % 32'hA);
    alarm_needs_estop <= 1'b0;
    wctl(4'h0, ps, 2'h0, 3'h0);
    wtime(11'h014, 11'h3E8);
    wph(SSSEL_RUN);
    main_power_ok <= 1'b0;
    repeat (10 * MS) @(posedge clk);
    main_power_ok <= 1'b1;
    repeat (5) @(posedge clk);
    cph(SSSEL_RUN);
    main_power_ok <= 1'b0;
    repeat (20 * MS - 4) @(posedge clk);
    cph(SSSEL_RUN);
    wph(SSSEL_DECEL);
    repeat (2) @(posedge clk);
    ck(eso(ps, 1'b0));
    wph(SSSEL_STOP);
    repeat (2) @(posedge clk);
    ck(eso(ps, 1'b1));
    main_power_ok <= 1'b1;
    repeat (5) @(posedge clk);
    chk({31'h0, servo_enable}, 32'h1, "resume");
    wctl(4'h0, 4'h0, 2'h1, 3'h1);
    wph(SSSEL_RUN);
    main_power_ok <= 1'b0;
    wph(SSSEL_DECEL);
    repeat (2) @(posedge clk);
    chk({31'h0, main_undervoltage_error}, 32'h1, "uv trip");
    ck(eal(3'h1, 1'b0, 1'b0));
    main_power_ok <= 1'b1;
    wr(`SSSEL_OFS_STATUS, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk({31'h0, main_undervoltage_error}, 32'h0, "uv clear");
    wctl(4'h0, 4'h0, 2'h0, 3'h0);
    wtime(11'h064, 11'h3E8);
    wph(SSSEL_RUN);
    main_power_ok <= 1'b0;
    repeat (10) @(posedge clk);
    bus_voltage_low <= 1'b1;
    repeat (5) @(posedge clk);
    chk({31'h0, main_undervoltage_error}, 32'h1, "bus low");
    bus_voltage_low <= 1'b0;
    main_power_ok <= 1'b1;
    wr(`SSSEL_OFS_STATUS, 32'h0000_0004);
    wctl(4'h0, 4'h0, 2'h2, 3'h0);
    wtime(11'h064, 11'h00A);
    servo_on_cmd <= 1'b0;
    wph(SSSEL_STOP);
    main_power_ok <= 1'b0;
    repeat (5 * MS) @(posedge clk);
    chk({31'h0, power_off_warning}, 32'h0, "warn early");
    repeat (10 * MS) @(posedge clk);
    chk({31'h0, power_off_warning}, 32'h1, "warn always");
    main_power_ok <= 1'b1;
    wctl(4'h0, 4'h0, 2'h0, 3'h0);
    main_power_ok <= 1'b0;
    repeat (15 * MS) @(posedge clk);
    chk({31'h0, power_off_warning}, 32'h0, "warn servo on only");
    main_power_ok <= 1'b1;
    wctl(4'h0, 4'h0, 2'h1, 3'h0);
    wtime(11'h7D0, 11'h00A);
    servo_on_cmd <= 1'b1;
    wph(SSSEL_RUN);
    main_power_ok <= 1'b0;
    repeat (2010 * MS) @(posedge clk);
    chk({30'h0, main_undervoltage_error, power_off_warning}, 32'h0, "det off");
    cph(SSSEL_RUN);
    main_power_ok <= 1'b1;
    complete_run();
  end
endmodule

`default_nettype wire
